// [windowed_watchdog_downcounter.sv]
// watchdog: prescaled 7-bit downcounter, arm bit, reset pulse generator
// assumes synchronous avalon-mm master and option straps held static
//
// Functional notes
// - counter steps down each prescaler period
// - armed 40h to 3Fh starts reset pulse
// - counter runs free even when disarmed
// - arm cleared only by reset
// - arm write with top bit clear resets
// - armed halt gives reset unless option
// - register write leaves prescaler untouched
// - hardware option forces armed state
// - arm bit 7, count 6..0, reset 7Fh
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ns
module windowed_watchdog_downcounter
    import wdog_pkg::*;
#(
    parameter int PRESCALE = wdog_pkg::PRESCALE_CYCLES,
    parameter int PULSE    = wdog_pkg::RST_PULSE_CYC
)
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // avalon-mm slave
    input  wire logic [9:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // option straps and cpu status
    input  wire logic              hw_watchdog_option,
    input  wire logic              halt_without_reset_option,
    input  wire logic              halt_request,
    // reset pin
    output logic                   reset_pin_n
);
    import wdog_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic              armed;
        logic [CNT_W-1:0]  count;
        logic [31:0]       prescale;
        logic [31:0]       pulse;
        logic              ack;
        logic [31:0]       rdata;
        logic [31:0]       low_run;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic   armed_eff;
    logic   hit;
    logic   wr_ctrl;
    logic   tick;
    logic   trip;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt    = st_r;
        armed_eff = st_r.armed | hw_watchdog_option;
        hit       = avs_address == CTRL_ADDR;
        wr_ctrl   = avs_write & hit & avs_byteenable[0] & st_r.ack;
        tick      = st_r.prescale == 32'(PRESCALE - 1);
        trip      = 1'b0;
        st_nxt.ack = (avs_read | avs_write) & ~st_r.ack;
        if (avs_read & ~st_r.ack)
        begin
            st_nxt.rdata = hit ? {24'h000000, st_r.armed, st_r.count} : UNMAPPED_DATA;
        end
        st_nxt.prescale = tick ? 32'h00000000 : st_r.prescale + 32'h00000001;
        if (tick)
        begin
            st_nxt.count = st_r.count - CNT_ONE;
            if (armed_eff && st_r.count == CNT_TRIP_FROM)
            begin
                trip = 1'b1;
            end
        end
        if (wr_ctrl)
        begin
            st_nxt.count = avs_writedata[CNT_W-1:0];
            st_nxt.armed = st_r.armed | avs_writedata[ARM_BIT];
            if ((avs_writedata[ARM_BIT] | armed_eff) && !avs_writedata[TOP_BIT])
            begin
                trip = 1'b1;
            end
        end
        if (halt_request && armed_eff && !halt_without_reset_option)
        begin
            trip = 1'b1;
        end
        if (st_r.pulse != 32'h00000000)
        begin
            st_nxt.pulse = st_r.pulse - 32'h00000001;
        end
        else if (trip)
        begin
            st_nxt.pulse = 32'(PULSE);
        end
        st_nxt.low_run = (st_r.pulse == 32'h00000000) ? 32'h00000000
                                                      : st_r.low_run + 32'h00000001;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_r          <= '0;
            st_r.count    <= CTRL_RESET[CNT_W-1:0];
            st_r.armed    <= CTRL_RESET[ARM_BIT];
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;
    assign avs_readdata    = st_r.rdata;
    assign reset_pin_n     = st_r.pulse == 32'h00000000;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_trip_step;
        tick && armed_eff && st_r.count == CNT_TRIP_FROM && st_r.pulse == 0 && !wr_ctrl;
    endsequence

    sequence s_sw_reset_write;
        wr_ctrl && avs_writedata[ARM_BIT] && !avs_writedata[TOP_BIT] && st_r.pulse == 0;
    endsequence

    sequence s_request_first;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    AST_ROLL_RESET: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_trip_step |=> !reset_pin_n)
        else $error("rollover did not pull reset");

    AST_PULSE_LEN: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(reset_pin_n) |-> st_r.low_run == 32'(PULSE))
        else $error("reset pulse length wrong");

    AST_NO_TRIP_DISARMED: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tick && !armed_eff && !wr_ctrl && !halt_request && st_r.pulse == 0 |=> reset_pin_n)
        else $error("reset while disarmed");

    AST_ARM_SET: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_ctrl && avs_writedata[ARM_BIT] |=> st_r.armed)
        else $error("arm bit not set by write");

    AST_HALT_OPT: assert property (@(posedge sys_clk) disable iff (sys_rst)
        halt_request && halt_without_reset_option && st_r.pulse == 0 && !tick && !wr_ctrl
        |=> reset_pin_n)
        else $error("halt reset despite option");

    AST_RESET_VAL: assert property (@(posedge sys_clk)
        sys_rst |=> st_r.count == CTRL_RESET[CNT_W-1:0] && st_r.armed == CTRL_RESET[ARM_BIT])
        else $error("register reset value wrong");

    AST_WRITE_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_ctrl |=> st_r.count == $past(avs_writedata[CNT_W-1:0]))
        else $error("write did not load count");

    AST_WAIT_ONE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_request_first |=> !avs_waitrequest)
        else $error("wait state too long");
    AST_FREE_RUN: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tick && !wr_ctrl |=> st_r.count == $past(st_r.count) - CNT_ONE)
        else $error("counter did not step");
    AST_ARM_STICKY: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_r.armed |=> st_r.armed)
        else $error("arm bit cleared without reset");
    AST_SW_RESET: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_sw_reset_write |=> ##1 !reset_pin_n)
        else $error("software reset missing");
    AST_HALT: assert property (@(posedge sys_clk) disable iff (sys_rst)
        halt_request && armed_eff && !halt_without_reset_option && st_r.pulse == 0
        |-> ##[1:2] !reset_pin_n)
        else $error("halt did not reset");
    AST_PRESCALE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_ctrl && !tick |=> st_r.prescale == $past(st_r.prescale) + 1)
        else $error("write disturbed prescaler");
    AST_HW_OPT: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hw_watchdog_option |-> armed_eff)
        else $error("hardware option not armed");
    AST_READ: assert property (@(posedge sys_clk) disable iff (sys_rst)
        avs_read && hit && !avs_waitrequest |-> avs_readdata[7:0] == $past({st_r.armed, st_r.count}))
        else $error("read data wrong");
    AST_STEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tick |=> st_r.prescale == 0)
        else $error("prescaler period wrong");
endmodule

// [wdog_pkg.sv]
// constants for the windowed watchdog downcounter
// assumes a 50 MHz system clock and an avalon-mm register slave
package wdog_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_INDEX     = 8'h2E;
    localparam int         ADDR_W         = 10;
    localparam logic [9:0] CTRL_ADDR      = 10'(CTRL_INDEX) << 2;
    localparam logic [7:0] CTRL_RESET     = 8'h7F;
    localparam int         ARM_BIT        = 7;
    localparam int         TOP_BIT        = 6;
    localparam int         CNT_W          = 7;
    localparam logic [6:0] CNT_ONE        = 7'h01;
    localparam logic [6:0] CNT_TRIP_FROM  = 7'h40;
    localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 50_000_000;
    localparam int PRESCALE_CYCLES = 16000;
    localparam int RST_PULSE_NS    = 36000;
    localparam int RST_PULSE_CYC   = (RST_PULSE_NS / 1000) * (CLK_HZ / 1_000_000);
endpackage

// [test_windowed_watchdog_downcounter.sv]
// self-checking bench for the watchdog downcounter
// assumes wdog_pkg compiled first; short prescale and pulse counts
`timescale 1ns/1ns
module test_windowed_watchdog_downcounter;
    import wdog_pkg::*;
    localparam int PS = 16;
    localparam int PW = 4;
    typedef struct {logic [9:0] wa; logic [31:0] wd; logic [3:0] be; logic [9:0] ra;
        logic [31:0] ex;} row_t;
    logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, reset_pin_n;
    logic        hw_watchdog_option, halt_without_reset_option, halt_request;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable;
    int          fails, tests_run, low_cnt;
    row_t        rows [4] = '{'{CTRL_ADDR, 32'h3A, 4'hF, CTRL_ADDR, 32'h3A},
        '{CTRL_ADDR, 32'h55, 4'h0, CTRL_ADDR, 32'h7F}, '{10'h000, 32'h12, 4'hF, CTRL_ADDR, 32'h7F},
        '{CTRL_ADDR, 32'h00, 4'hF, 10'h004, UNMAPPED_DATA}};
    windowed_watchdog_downcounter #(.PRESCALE(PS), .PULSE(PW)) dut (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .hw_watchdog_option(hw_watchdog_option), .halt_request(halt_request),
        .halt_without_reset_option(halt_without_reset_option), .reset_pin_n(reset_pin_n));
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // counts cycles with the reset pin pulled low
    always @(posedge sys_clk)
        if (reset_pin_n === 1'b0) low_cnt <= low_cnt + 1;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp, input bit tol);
        logic [31:0] lo;
        lo = {exp[31:7], exp[6:0] - 7'h01};
        tests_run++;
        if (!(seen === exp || (tol && seen === lo)))
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input bit rdn, input logic [9:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a; avs_read <= rdn; avs_write <= !rdn;
        avs_writedata <= d; avs_byteenable <= be;
        do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0; avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin fails++; tally_and_finish(); end
    endtask
    task automatic pulse(input int cyc, input int exp);
        int s;
        s = low_cnt;
        repeat (cyc) @(posedge sys_clk);
        chk("pulse_len", 32'(low_cnt - s), 32'(exp), 1'b0);
    endtask
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask
    task automatic halt_once();
        @(posedge sys_clk) halt_request <= 1'b1;
        @(posedge sys_clk) halt_request <= 1'b0;
    endtask
    initial
    begin
        sys_rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = '0;
        avs_writedata = '0; avs_byteenable = '0; halt_request = 1'b0;
        hw_watchdog_option = 1'b0; halt_without_reset_option = 1'b0; fails = 0; tests_run = 0;
        do_reset();
        bus(1'b1, CTRL_ADDR, '0, 4'hF);
        chk("ctrl_reset", rd, 32'(CTRL_RESET), 1'b0);
        chk("pin_idle", {31'h0, reset_pin_n}, 32'h1, 1'b0);
        foreach (rows[i])
        begin
            bus(1'b0, CTRL_ADDR, 32'h7F, 4'hF);
            bus(1'b0, rows[i].wa, rows[i].wd, rows[i].be);
            bus(1'b1, rows[i].ra, '0, 4'hF);
            chk("row_read", rd, rows[i].ex, rows[i].ra == CTRL_ADDR);
        end
        bus(1'b0, CTRL_ADDR, 32'h7F, 4'hF);
        repeat (PS * 4 - 4) @(posedge sys_clk);
        bus(1'b1, CTRL_ADDR, '0, 4'hF);
        chk("tick_count", rd, 32'h7C, 1'b1);
        bus(1'b0, CTRL_ADDR, 32'h41, 4'hF);
        pulse(PS * 4 - 4, 0);
        bus(1'b1, CTRL_ADDR, '0, 4'hF);
        chk("free_run_top", {31'h0, rd[TOP_BIT]}, 32'h0, 1'b0);
        bus(1'b0, CTRL_ADDR, 32'hBF, 4'hF);
        pulse(PW + 4, PW);
        do_reset();
        bus(1'b1, CTRL_ADDR, '0, 4'hF);
        chk("arm_after_reset", {31'h0, rd[ARM_BIT]}, 32'h0, 1'b0);
        bus(1'b0, CTRL_ADDR, 32'hC1, 4'hF);
        pulse(PS * 2 + PW + 8, PW);
        bus(1'b0, CTRL_ADDR, 32'h7F, 4'hF);
        bus(1'b1, CTRL_ADDR, '0, 4'hF);
        chk("arm_sticky", rd, 32'hFF, 1'b1);
        halt_once();
        pulse(PW + 4, PW);
        halt_without_reset_option <= 1'b1;
        halt_once();
        pulse(PW + 4, 0);
        halt_without_reset_option <= 1'b0;
        do_reset();
        hw_watchdog_option <= 1'b1;
        bus(1'b0, CTRL_ADDR, 32'h41, 4'hF);
        pulse(PS * 2 + PW + 8, PW);
        tally_and_finish();
    end
endmodule
